// ===== video_output_settings_control_tb_top.sv
// Self-checking testbench of the settings control block
`include "vosc_defs.svh"
`default_nettype none
module video_output_settings_control_tb_top
	import vosc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, reset_n = 1'b0, read, write;
	logic [4:0] address;
	logic [3:0] byteenable, nv_load_idx, nv_idx, select_led;
	logic [31:0] writedata, readdata, rd;
	logic waitrequest, mode_btn, right_btn, left_btn, nv_load_valid;
	logic nv_write, edit_led, blink_led;
	logic [1:0] section_led;
	vosc_par_type nv_load_data, nv_data;
	vosc_cfg_type cfg;
	vosc_status_type stat_in;
	int n_errors = 0, total_checks = 0, cyc = 0;
	vosc_ctrl #(.COMMIT_CYCLES(32'h0000_0032), .BLINK_CYCLES(32'h0000_0004))
	vosc_ctrl_i (.clock, .reset_n, .address, .read, .write, .byteenable,
		.writedata, .readdata, .waitrequest, .mode_btn, .right_btn, .left_btn,
		.stat_in, .nv_load_valid, .nv_load_idx, .nv_load_data, .nv_write,
		.nv_idx, .nv_data, .edit_led, .section_led, .select_led, .blink_led,
		.cfg);
	vosc_panel_model vosc_panel_model_i (.clock, .reset_n, .mode_btn,
		.right_btn, .left_btn, .nv_write, .nv_idx, .nv_data, .nv_load_valid,
		.nv_load_idx, .nv_load_data);
	// Clock and a cycle ceiling against hangs
	initial forever #2 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [3:0] be, input logic [31:0] d);
		int k;
		@(posedge clock);
		address <= a;
		byteenable <= be;
		writedata <= d;
		write <= wr;
		read <= !wr;
		for (k = 0; k < 20; k++) begin
			@(posedge clock);
			if (waitrequest === 1'b0)
				break;
		end
		rd = readdata;
		chk(k < 20, 1, "bus answer");
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (20) @(posedge clock);
	endtask
	task automatic t_defaults();
		bus(0, `VOSC_REG_CTRL, 4'hF, 0);
		chk(rd, 32'h0000_0100, "ctrl reset");
		chk({cfg.width, cfg.height}, {2{12'sh064}}, "size");
		chk({cfg.gain, cfg.chroma}, {2{12'sh064}}, "amp");
		chk({cfg.hpos, cfg.vpos}, 0, "pos");
		chk({cfg.pedestal, cfg.hue}, 0, "ped hue");
		chk({cfg.htime, cfg.vtime}, 0, "timing");
		$display("defaults done");
	endtask
	task automatic t_ctrl();
		stat_in <= vosc_status_type'(8'h01);
		bus(1, `VOSC_REG_CTRL, 4'hF, 32'h0000_ACFD);
		bus(1, `VOSC_REG_PAR0, 4'h3, 32'h0000_0008);
		repeat (3) @(posedge clock);
		chk({cfg.ref_ext, cfg.noise_red, cfg.detail}, 5'h1B, "rnd");
		chk({cfg.setup_on, cfg.vblank_last}, 6'h34, "w525");
		chk({cfg.mute_black, cfg.caption_pass}, 2'h2, "mute");
		chk({cfg.grat_mode, cfg.grat_target, cfg.grat_color}, 7'h4D, "gr");
		chk({cfg.aspect, cfg.manual_apply}, 5'h11, "manual");
		stat_in <= vosc_status_type'(8'h41);
		bus(1, `VOSC_REG_CTRL, 4'hF, 32'h0000_0100);
		bus(1, `VOSC_REG_PAR0, 4'h3, 32'h0000_0005);
		repeat (3) @(posedge clock);
		chk({cfg.setup_on, cfg.vblank_last}, 6'h06, "n625");
		chk({cfg.mute_black, cfg.caption_pass}, 2'h1, "pass");
		chk({cfg.aspect, cfg.manual_apply}, 5'h0A, "crop");
		$display("ctrl done");
	endtask
	task automatic t_status();
		for (int i = 0; i < 24; i++) begin
			stat_in <= vosc_status_type'({2'(i / 6), 2'(i % 3), 3'(i % 6), 1'(i)});
			bus(0, `VOSC_REG_STAT, 4'hF, 0);
			chk(rd[7:0], {2'(i / 6), 2'(i % 3), 3'(i % 6), 1'(i)}, "st");
		end
		$display("status done");
	endtask
	task automatic t_clamp();
		vosc_par_type hi [12] = '{`VOSC_ASP_MAX, `VOSC_WIDTH_MAX,
			`VOSC_HEIGHT_MAX, `VOSC_PCT_100, `VOSC_PCT_100, `VOSC_AMP_MAX,
			`VOSC_AMP_MAX, `VOSC_PED_MAX, `VOSC_HUE_MAX, `VOSC_HT_MAX,
			`VOSC_VT_MAX, `VOSC_PCT_100};
		vosc_par_type lo [12] = '{`VOSC_ZERO, `VOSC_SIZE_MIN, `VOSC_SIZE_MIN,
			`VOSC_POS_MIN, `VOSC_POS_MIN, `VOSC_ZERO, `VOSC_ZERO, `VOSC_PED_MIN,
			`VOSC_HUE_MIN, `VOSC_HT_MIN, `VOSC_VT_MIN, `VOSC_ZERO};
		for (int i = 0; i < 24; i++) begin
			bus(1, 5'(4 + (i % 12) / 2 * 4), (i % 2) ? 4'hC : 4'h3,
				(i < 12) ? 32'h07FF_07FF : 32'h0800_0800);
			bus(0, 5'(4 + (i % 12) / 2 * 4), 4'hF, 0);
			chk((i % 2) ? rd[27:16] : rd[11:0],
				{(i < 12) ? hi[i] : lo[i % 12]},
				"sat");
		end
		chk({cfg.width, cfg.gain}, {`VOSC_SIZE_MIN, `VOSC_ZERO}, "cfg");
		$display("clamp done");
	endtask
	task automatic t_mirror();
		bus(1, `VOSC_REG_CTRL, 4'hF, 32'h0001_0100);
		repeat (3) @(posedge clock);
		chk(cfg.hflip, 1, "flip on");
		bus(1, `VOSC_REG_CTRL, 4'hF, 32'h0000_0100);
		repeat (3) @(posedge clock);
		chk(cfg.hflip, 1, "flip held");
		bus(0, `VOSC_REG_STAT, 4'hF, 0);
		chk(rd[17], 1, "flip off waits");
		do_reset();
		chk(cfg.hflip, 0, "flip off");
		$display("mirror done");
	endtask
	task automatic push(input logic [2:0] b);
		vosc_panel_model_i.set_btn(b);
		vosc_panel_model_i.set_btn(3'h0);
	endtask
	// Enter section 1, browse to height and back to width, enter adjust by chord, step it up once
	task automatic edit_width(input vosc_par_type exp);
		logic b;
		push(3'h4);
		chk(edit_led, 1, "edit on");
		push(3'h4);
		chk({section_led, select_led}, 6'h11, "sec1");
		push(3'h2);
		chk(select_led, 4'h2, "browse");
		push(3'h1);
		vosc_panel_model_i.set_btn(3'h1);
		vosc_panel_model_i.set_btn(3'h3);
		vosc_panel_model_i.set_btn(3'h0);
		push(3'h2);
		chk(cfg.width, exp, "step");
		bus(0, `VOSC_REG_STAT, 4'hF, 0);
		chk(rd[18], 1, "pending");
		b = blink_led;
		repeat (4) @(posedge clock);
		chk(blink_led, !b, "blink");
	endtask
	task automatic t_panel();
		edit_width(12'sh065);
		repeat (70) @(posedge clock);
		chk(vosc_panel_model_i.n_commits, 1, "commit");
		chk(vosc_panel_model_i.mem[1], 12'sh065, "stored");
		chk(edit_led, 0, "edit off");
		chk(blink_led, 0, "blink off");
		edit_width(12'sh066);
		do_reset();
		chk(cfg.width, 12'sh065, "restored");
		chk(vosc_panel_model_i.n_commits, 1, "no commit");
		$display("panel done");
	endtask
	initial begin
		{read, write, address, byteenable, writedata} <= '0;
		stat_in <= '0;
		do_reset();
		t_defaults();
		t_ctrl();
		t_status();
		t_clamp();
		t_mirror();
		t_panel();
		wrap_up();
	end
endmodule // video_output_settings_control_tb_top
`default_nettype wire

// ===== vosc_ctrl.sv
// Front-panel editor, host settings registers and status of the converter
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "vosc_defs.svh"
`default_nettype none
module vosc_ctrl
	import vosc_pkg::*;
#(
	parameter logic [31:0] COMMIT_CYCLES =
		32'(`VOSC_COMMIT_MS * `VOSC_CLK_KHZ),
	parameter logic [31:0] BLINK_CYCLES =
		32'(`VOSC_BLINK_MS * `VOSC_CLK_KHZ)
) (
	input  wire logic            clock,
	input  wire logic            reset_n,
	input  wire logic [4:0]      address,
	input  wire logic            read,
	input  wire logic            write,
	input  wire logic [3:0]      byteenable,
	input  wire logic [31:0]     writedata,
	output var  logic [31:0]     readdata,
	output var  logic            waitrequest,
	input  wire logic            mode_btn,
	input  wire logic            right_btn,
	input  wire logic            left_btn,
	input  wire vosc_status_type stat_in,
	input  wire logic            nv_load_valid,
	input  wire logic [3:0]      nv_load_idx,
	input  wire vosc_par_type    nv_load_data,
	output var  logic            nv_write,
	output var  logic [3:0]      nv_idx,
	output var  vosc_par_type    nv_data,
	output var  logic            edit_led,
	output var  logic [1:0]      section_led,
	output var  logic [3:0]      select_led,
	output var  logic            blink_led,
	output var  vosc_cfg_type    cfg
);
	// Range limits and defaults of each parameter
	function automatic vosc_par_type lim_min(input logic [3:0] i);
		unique case (i)
			`VOSC_P_WIDTH, `VOSC_P_HEIGHT: lim_min = `VOSC_SIZE_MIN;
			`VOSC_P_HPOS, `VOSC_P_VPOS:    lim_min = `VOSC_POS_MIN;
			`VOSC_P_PED:   lim_min = `VOSC_PED_MIN;
			`VOSC_P_HUE:   lim_min = `VOSC_HUE_MIN;
			`VOSC_P_HTIME: lim_min = `VOSC_HT_MIN;
			`VOSC_P_VTIME: lim_min = `VOSC_VT_MIN;
			default:       lim_min = `VOSC_ZERO;
		endcase
	endfunction

	function automatic vosc_par_type lim_max(input logic [3:0] i);
		unique case (i)
			`VOSC_P_ASPECT: lim_max = `VOSC_ASP_MAX;
			`VOSC_P_WIDTH:  lim_max = `VOSC_WIDTH_MAX;
			`VOSC_P_HEIGHT: lim_max = `VOSC_HEIGHT_MAX;
			`VOSC_P_GAIN, `VOSC_P_CHROMA: lim_max = `VOSC_AMP_MAX;
			`VOSC_P_PED:   lim_max = `VOSC_PED_MAX;
			`VOSC_P_HUE:   lim_max = `VOSC_HUE_MAX;
			`VOSC_P_HTIME: lim_max = `VOSC_HT_MAX;
			`VOSC_P_VTIME: lim_max = `VOSC_VT_MAX;
			default:       lim_max = `VOSC_PCT_100;
		endcase
	endfunction

	function automatic vosc_par_type lim_def(input logic [3:0] i);
		unique case (i)
			`VOSC_P_WIDTH, `VOSC_P_HEIGHT: lim_def = `VOSC_PCT_100;
			`VOSC_P_GAIN, `VOSC_P_CHROMA:  lim_def = `VOSC_PCT_100;
			`VOSC_P_ALPHA: lim_def = `VOSC_PCT_100;
			default:       lim_def = `VOSC_ZERO;
		endcase
	endfunction

	// Saturate a widened value into the range of parameter i
	function automatic vosc_par_type clamp(input logic [3:0] i,
		input logic signed [12:0] v);
		if (v < 13'(lim_min(i)))
			clamp = lim_min(i);
		else if (v > 13'(lim_max(i)))
			clamp = lim_max(i);
		else
			clamp = v[11:0];
	endfunction

	// First and last parameter of each panel section
	function automatic logic [3:0] sec_first(input logic [1:0] s);
		unique case (s)
			2'h0: sec_first = `VOSC_P_ASPECT;
			2'h1: sec_first = `VOSC_SEC1_FIRST;
			2'h2: sec_first = `VOSC_SEC2_FIRST;
			2'h3: sec_first = `VOSC_SEC3_FIRST;
		endcase
	endfunction

	function automatic logic [3:0] sec_last(input logic [1:0] s);
		sec_last = (s == 2'h3) ? `VOSC_P_ALPHA : sec_first(s + 2'h1) - 4'h1;
	endfunction

	logic [2:0]    btn_meta_r, btn_sync_r, btn_prev_r;
	vosc_edit_type ed_r, ed_nxt;
	logic [1:0]    sec_r, sec_nxt;
	logic [3:0]    cur_r, cur_nxt;
	vosc_par_type  par_r [`VOSC_NPAR];
	vosc_par_type  par_nxt [`VOSC_NPAR];
	logic [16:0]   ctrl_r;
	logic          flip_r, pend_r;
	logic [3:0]    pend_idx_r;
	logic [31:0]   cnt_r, blink_cnt_r;
	logic          wait_r, nv_write_r, blink_r, edit_on_r;
	logic [31:0]   rdata_r;

	// Button edges after the two-stage synchroniser
	wire mode_press  = btn_sync_r[0] & ~btn_prev_r[0];
	wire right_press = btn_sync_r[1] & ~btn_prev_r[1];
	wire left_press  = btn_sync_r[2] & ~btn_prev_r[2];
	wire chord = (right_press & btn_sync_r[2]) | (left_press & btn_sync_r[1]);
	wire right_only = right_press & ~btn_sync_r[2];
	wire left_only  = left_press & ~btn_sync_r[1];
	wire ed_off     = (ed_r == VOSC_ED_OFF);
	wire adjusting  = (ed_r == VOSC_ED_ADJUST);
	wire step_ev    = adjusting & ~mode_press & (right_only | left_only);
	wire expire     = pend_r & (cnt_r == COMMIT_CYCLES - 32'h0000_0001);
	wire switch_ev  = step_ev & pend_r & (pend_idx_r != cur_r);

	// Bus decode; a write takes effect at the edge after the one that ends the wait
	wire        wr_acc  = write & ~wait_r;
	wire        is_ctrl = (address == `VOSC_REG_CTRL);
	wire        is_par  = (address >= `VOSC_REG_PAR0) &
		(address <= `VOSC_REG_PAR5);
	wire        is_stat = (address == `VOSC_REG_STAT);
	wire [2:0]  par_reg = address[4:2] - 3'h1;
	wire [3:0]  ev_idx  = {par_reg, 1'b0};
	wire [3:0]  od_idx  = {par_reg, 1'b1};
	wire [31:0] stat_word = {13'h0000, pend_r, ~ctrl_r[`VOSC_CTRL_FLIP] &
		flip_r, ed_r, sec_r, cur_r, stat_in};
	wire [31:0] rd_mux =
		is_ctrl ? {15'h0000, ctrl_r} :
		is_par  ? {4'h0, par_r[od_idx], 4'h0, par_r[ev_idx]} :
		is_stat ? stat_word : 32'h0000_0000;
	wire [31:0] wr_word;

	// Byte-lane merge of write data into the current register
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign wr_word[b*8 +: 8] = byteenable[b] ?
				writedata[b*8 +: 8] : rd_mux[b*8 +: 8];
		end
	endgenerate

	// Next value of each parameter: host write, else panel step, else load
	genvar p;
	generate
		for (p = 0; p < `VOSC_NPAR; p++) begin : g_par
			localparam logic [3:0] PI = 4'(p);
			wire host_hit = wr_acc & is_par & (par_reg == PI[3:1]);
			wire [11:0] host_val = PI[0] ? wr_word[`VOSC_PAR_HI] :
				wr_word[`VOSC_PAR_LO];
			wire step_hit = step_ev & (cur_r == PI);
			wire signed [12:0] stepped = {par_r[p][11], par_r[p]} +
				(right_only ? 13'sh0001 : 13'sh1FFF);
			assign par_nxt[p] =
				host_hit ? clamp(PI, {host_val[11], host_val}) :
				step_hit ? clamp(PI, stepped) :
				(nv_load_valid & (nv_load_idx == PI)) ?
					clamp(PI, {nv_load_data[11], nv_load_data}) :
				par_r[p];
		end
	endgenerate

	// Panel editor: section tabbing, selection and adjust toggling
	always_comb begin
		ed_nxt  = ed_r;
		sec_nxt = sec_r;
		cur_nxt = cur_r;
		if (mode_press) begin
			sec_nxt = ed_off ? 2'h0 : sec_r + 2'h1;
			ed_nxt  = VOSC_ED_BROWSE;
			cur_nxt = sec_first(sec_nxt);
		end else if (!ed_off && chord) begin
			ed_nxt = adjusting ? VOSC_ED_BROWSE : VOSC_ED_ADJUST;
		end else if (ed_r == VOSC_ED_BROWSE) begin
			if (right_only && cur_r != sec_last(sec_r))
				cur_nxt = cur_r + 4'h1;
			else if (left_only && cur_r != sec_first(sec_r))
				cur_nxt = cur_r - 4'h1;
		end else if (expire) begin
			ed_nxt = VOSC_ED_OFF;
		end
	end

	// Synchroniser and editor state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			btn_meta_r <= 3'h0;
			btn_sync_r <= 3'h0;
			btn_prev_r <= 3'h0;
			ed_r       <= VOSC_ED_OFF;
			sec_r      <= 2'h0;
			cur_r      <= 4'h0;
			edit_on_r  <= 1'b0;
		end else begin
			btn_meta_r <= {left_btn, right_btn, mode_btn};
			btn_sync_r <= btn_meta_r;
			btn_prev_r <= btn_sync_r;
			ed_r       <= ed_nxt;
			sec_r      <= sec_nxt;
			cur_r      <= cur_nxt;
			edit_on_r  <= (ed_nxt != VOSC_ED_OFF);
		end
	end

	// Parameter store; reset gives defaults, storage may reload after
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `VOSC_NPAR; i++)
				par_r[i] <= lim_def(4'(i));
		end else begin
			for (int i = 0; i < `VOSC_NPAR; i++)
				par_r[i] <= par_nxt[i];
		end
	end

	// Commit timer; an edit of another parameter commits the pending one
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pend_r      <= 1'b0;
			pend_idx_r  <= 4'h0;
			cnt_r       <= 32'h0000_0000;
			nv_write_r  <= 1'b0;
			nv_idx      <= 4'h0;
			nv_data     <= `VOSC_ZERO;
			blink_cnt_r <= 32'h0000_0000;
			blink_r     <= 1'b0;
		end else begin
			pend_r     <= step_ev | (pend_r & ~expire);
			pend_idx_r <= step_ev ? cur_r : pend_idx_r;
			cnt_r      <= step_ev ? 32'h0000_0000 :
				pend_r ? cnt_r + 32'h0000_0001 : cnt_r;
			nv_write_r <= expire | switch_ev;
			nv_idx     <= pend_idx_r;
			nv_data    <= par_r[pend_idx_r];
			blink_cnt_r <= (!pend_r ||
				blink_cnt_r == BLINK_CYCLES - 32'h0000_0001) ?
				32'h0000_0000 : blink_cnt_r + 32'h0000_0001;
			blink_r    <= pend_r & ~expire & (blink_cnt_r == 32'h0000_0000 ?
				~blink_r : blink_r);
		end
	end

	// Host control register, mirroring latch and bus handshake
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r  <= `VOSC_CTRL_RST;
			flip_r  <= 1'b0;
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			ctrl_r  <= (wr_acc & is_ctrl) ? wr_word[16:0] : ctrl_r;
			flip_r  <= flip_r | ctrl_r[`VOSC_CTRL_FLIP];
			wait_r  <= wait_r ? ~(read | write) : 1'b1;
			rdata_r <= (wait_r & read) ? rd_mux : rdata_r;
		end
	end

	// Settings to the video path, all registered
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= '0;
		end else begin
			cfg.ref_ext      <= ctrl_r[`VOSC_CTRL_REF];
			cfg.aspect       <= par_r[`VOSC_P_ASPECT][3:0];
			cfg.manual_apply <= (par_r[`VOSC_P_ASPECT][3:0] ==
				VOSC_ASP_MANUAL);
			cfg.width        <= par_r[`VOSC_P_WIDTH];
			cfg.height       <= par_r[`VOSC_P_HEIGHT];
			cfg.hpos         <= par_r[`VOSC_P_HPOS];
			cfg.vpos         <= par_r[`VOSC_P_VPOS];
			cfg.gain         <= par_r[`VOSC_P_GAIN];
			cfg.chroma       <= par_r[`VOSC_P_CHROMA];
			cfg.pedestal     <= par_r[`VOSC_P_PED];
			cfg.hue          <= par_r[`VOSC_P_HUE];
			cfg.htime        <= par_r[`VOSC_P_HTIME];
			cfg.vtime        <= par_r[`VOSC_P_VTIME];
			cfg.noise_red    <= ctrl_r[`VOSC_CTRL_NR];
			cfg.detail       <= ctrl_r[`VOSC_CTRL_DET];
			cfg.setup_on     <= ctrl_r[`VOSC_CTRL_SETUP] &
				(stat_in.in_std == VOSC_IN_525);
			cfg.vblank_last  <= (stat_in.in_std == VOSC_IN_625) ?
				(ctrl_r[`VOSC_CTRL_VBW] ? `VOSC_VB_W625 : `VOSC_VB_N625) :
				(ctrl_r[`VOSC_CTRL_VBW] ? `VOSC_VB_W525 : `VOSC_VB_N525);
			cfg.mute_black   <= ctrl_r[`VOSC_CTRL_MUTE] &
				stat_in.quality_bad;
			cfg.caption_pass <= ctrl_r[`VOSC_CTRL_CAPT];
			cfg.grat_mode    <= ctrl_r[`VOSC_CTRL_GRAT];
			cfg.grat_target  <= ctrl_r[`VOSC_CTRL_TGT];
			cfg.grat_color   <= ctrl_r[`VOSC_CTRL_COL];
			cfg.grat_alpha   <= par_r[`VOSC_P_ALPHA];
			cfg.hflip        <= flip_r;
		end
	end

	// Port drivers straight from flip-flops
	assign readdata    = rdata_r;
	assign waitrequest = wait_r;
	assign nv_write    = nv_write_r;
	assign edit_led    = edit_on_r;
	assign section_led = sec_r;
	assign select_led  = cur_r;
	assign blink_led   = blink_r;

	// Checks on the block's own behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sect_enter_a: assert property (ed_off && mode_press |=>
		ed_r == VOSC_ED_BROWSE && sec_r == 2'h0 && cur_r == 4'h0)
		else $error("mode press did not open section zero");
	sect_next_a: assert property (!ed_off && mode_press |=>
		sec_r == $past(sec_r) + 2'h1)
		else $error("mode press did not advance the section");
	arrow_inc_a: assert property (step_ev && right_only &&
		!(wr_acc && is_par) && !nv_load_valid &&
		par_r[cur_r] < lim_max(cur_r) |=>
		par_r[$past(cur_r)] == $past(par_r[cur_r]) + 12'sh001)
		else $error("right arrow did not increment");
	commit_time_a: assert property (nv_write_r && !$past(switch_ev) |->
		$past(cnt_r) == COMMIT_CYCLES - 32'h0000_0001)
		else $error("commit happened at the wrong time");
	sat_range_a: assert property (par_r[cur_r] >= lim_min(cur_r) &&
		par_r[cur_r] <= lim_max(cur_r))
		else $error("selected parameter out of range");
	setup_525_a: assert property (cfg.setup_on |->
		$past(stat_in.in_std) == VOSC_IN_525)
		else $error("setup applied to non-525 output");
	mute_black_a: assert property (##1 cfg.mute_black ==
		($past(ctrl_r[`VOSC_CTRL_MUTE]) && $past(stat_in.quality_bad)))
		else $error("muting does not follow quality");
	flip_hold_a: assert property (cfg.hflip |=> cfg.hflip)
		else $error("mirroring turned off without reset");
	manual_sel_a: assert property (##1 cfg.manual_apply ==
		($past(par_r[`VOSC_P_ASPECT]) == `VOSC_ASP_MAX))
		else $error("manual apply mismatch");

	commit_c: cover property (expire ##1 nv_write_r);
	adjust_c: cover property (chord && !ed_off ##1 adjusting);
	flip_c:   cover property ($rose(cfg.hflip));
	bus_c:    cover property (wr_acc && is_par);
endmodule // vosc_ctrl
`default_nettype wire

// ===== vosc_defs.svh
// Register map, field positions, limits, defaults and timing constants
`ifndef VOSC_DEFS_SVH
`define VOSC_DEFS_SVH
`define VOSC_REG_CTRL      5'h00
`define VOSC_REG_PAR0      5'h04
`define VOSC_REG_PAR5      5'h18
`define VOSC_REG_STAT      5'h1C
`define VOSC_CTRL_RST      17'h0_0100
`define VOSC_CTRL_REF      0
`define VOSC_CTRL_NR       2:1
`define VOSC_CTRL_DET      4:3
`define VOSC_CTRL_SETUP    5
`define VOSC_CTRL_VBW      6
`define VOSC_CTRL_MUTE     7
`define VOSC_CTRL_CAPT     8
`define VOSC_CTRL_GRAT     10:9
`define VOSC_CTRL_TGT      12:11
`define VOSC_CTRL_COL      15:13
`define VOSC_CTRL_FLIP     16
`define VOSC_PAR_LO        11:0
`define VOSC_PAR_HI        27:16
`define VOSC_NPAR          12
`define VOSC_P_ASPECT      4'h0
`define VOSC_P_WIDTH       4'h1
`define VOSC_P_HEIGHT      4'h2
`define VOSC_P_HPOS        4'h3
`define VOSC_P_VPOS        4'h4
`define VOSC_P_GAIN        4'h5
`define VOSC_P_CHROMA      4'h6
`define VOSC_P_PED         4'h7
`define VOSC_P_HUE         4'h8
`define VOSC_P_HTIME       4'h9
`define VOSC_P_VTIME       4'hA
`define VOSC_P_ALPHA       4'hB
`define VOSC_ZERO          12'sh000
`define VOSC_ASP_MAX       12'sh008
`define VOSC_SIZE_MIN      12'sh01E
`define VOSC_WIDTH_MAX     12'sh091
`define VOSC_HEIGHT_MAX    12'sh08C
`define VOSC_PCT_100       12'sh064
`define VOSC_POS_MIN       12'shF9C
`define VOSC_AMP_MAX       12'sh096
`define VOSC_PED_MIN       12'shFE2
`define VOSC_PED_MAX       12'sh01E
`define VOSC_HUE_MIN       12'shF4C
`define VOSC_HUE_MAX       12'sh0B4
`define VOSC_HT_MIN        12'sh830
`define VOSC_HT_MAX        12'sh7D0
`define VOSC_VT_MIN        12'shC18
`define VOSC_VT_MAX        12'sh3E8
`define VOSC_SEC1_FIRST    4'h1
`define VOSC_SEC2_FIRST    4'h5
`define VOSC_SEC3_FIRST    4'h9
`define VOSC_VB_N525       5'h09
`define VOSC_VB_N625       5'h06
`define VOSC_VB_W525       5'h14
`define VOSC_VB_W625       5'h16
`define VOSC_COMMIT_MS     64'h0000_3A98
`define VOSC_BLINK_MS      64'h0000_00FA
`define VOSC_CLK_KHZ       64'h0003_D090
`endif

// ===== vosc_panel_model.sv
// Front panel buttons and non-volatile storage model for the settings block
`default_nettype none
module vosc_panel_model
	import vosc_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         reset_n,
	output var  logic         mode_btn,
	output var  logic         right_btn,
	output var  logic         left_btn,
	input  wire logic         nv_write,
	input  wire logic [3:0]   nv_idx,
	input  wire vosc_par_type nv_data,
	output var  logic         nv_load_valid,
	output var  logic [3:0]   nv_load_idx,
	output var  vosc_par_type nv_load_data
);
	timeunit 1ns;
	timeprecision 1ps;
	vosc_par_type mem [12];
	logic [11:0]  kept = 12'h000;
	logic [4:0]   ptr;
	int           n_commits = 0;
	initial {mode_btn, right_btn, left_btn} = 3'h0;
	// Storage keeps its contents through reset; only a commit updates it
	always @(posedge clock) begin
		if (nv_write) begin
			mem[nv_idx] <= nv_data;
			kept[nv_idx] <= 1'b1;
			n_commits <= n_commits + 1;
		end
	end
	// Replays every stored value, one per cycle, after each reset
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ptr <= 5'h00;
			nv_load_valid <= 1'b0;
		end else begin
			nv_load_valid <= (ptr < 5'h0C) && kept[ptr[3:0]];
			nv_load_idx <= ptr[3:0];
			nv_load_data <= (ptr < 5'h0C) ? mem[ptr[3:0]] : ~nv_load_data;
			if (ptr < 5'h0C)
				ptr <= ptr + 5'h01;
		end
	end
	// Sets the pins {mode, right, left} and holds them long enough to sync
	task automatic set_btn(input logic [2:0] b);
		@(posedge clock);
		{mode_btn, right_btn, left_btn} <= b;
		repeat (6) @(posedge clock);
	endtask
endmodule // vosc_panel_model
`default_nettype wire

// ===== vosc_pkg.sv
// Types shared by the settings control block
`default_nettype none
package vosc_pkg;
	typedef logic signed [11:0] vosc_par_type;
	typedef enum logic [1:0] {
		VOSC_IN_525 = 2'h0, VOSC_IN_625 = 2'h1,
		VOSC_IN_NONE = 2'h2, VOSC_IN_UNKNOWN = 2'h3
	} vosc_in_std_type;
	typedef enum logic [1:0] {
		VOSC_CC_NONE = 2'h0, VOSC_CC_LINE21 = 2'h1, VOSC_CC_708 = 2'h2
	} vosc_cc_type;
	typedef enum logic [2:0] {
		VOSC_REF_MISMATCH = 3'h0, VOSC_REF_UNLOCKED = 3'h1,
		VOSC_REF_TRILEVEL_SYNC_LOCKED = 3'h2, VOSC_REF_ABSENT = 3'h3,
		VOSC_REF_LOCK_525 = 3'h4, VOSC_REF_LOCK_625 = 3'h5
	} vosc_ref_type;
	typedef enum logic [3:0] {
		VOSC_ASP_ANAMORPHIC = 4'h0, VOSC_ASP_LB_16_9 = 4'h1,
		VOSC_ASP_LB_14_9 = 4'h2, VOSC_ASP_LB_13_9 = 4'h3,
		VOSC_ASP_PILLAR = 4'h4, VOSC_ASP_CROP_75 = 4'h5,
		VOSC_ASP_CROP_84 = 4'h6, VOSC_ASP_CROP_TB = 4'h7,
		VOSC_ASP_MANUAL = 4'h8
	} vosc_aspect_type;
	typedef enum logic [2:0] {
		VOSC_ED_OFF = 3'b001, VOSC_ED_BROWSE = 3'b010, VOSC_ED_ADJUST = 3'b100
	} vosc_edit_type;
	// Status reported by the video path
	typedef struct packed {
		vosc_in_std_type in_std;
		vosc_cc_type     cc;
		vosc_ref_type    ref_st;
		logic            quality_bad;
	} vosc_status_type;
	// Settings that steer the video path
	typedef struct packed {
		logic         ref_ext;
		logic [3:0]   aspect;
		logic         manual_apply;
		vosc_par_type width;
		vosc_par_type height;
		vosc_par_type hpos;
		vosc_par_type vpos;
		vosc_par_type gain;
		vosc_par_type chroma;
		vosc_par_type pedestal;
		vosc_par_type hue;
		vosc_par_type htime;
		vosc_par_type vtime;
		logic [1:0]   noise_red;
		logic [1:0]   detail;
		logic         setup_on;
		logic [4:0]   vblank_last;
		logic         mute_black;
		logic         caption_pass;
		logic [1:0]   grat_mode;
		logic [1:0]   grat_target;
		logic [2:0]   grat_color;
		vosc_par_type grat_alpha;
		logic         hflip;
	} vosc_cfg_type;
endpackage
`default_nettype wire
